// ---- hdl/mrpc_pkg.sv ----
// Constants shared by the rate, preamble and MAC configuration block.
// Assumes a 125 MHz core clock and a 10-bit register address space.
package mrpc_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register space
   localparam int REG_ADDR_W = 10;
   localparam logic [9:0] MAC_CONTROL_ONE_OFS = 10'h010;
   localparam logic [9:0] RATE_CONFIGURATION_OFS = 10'h036;
   localparam logic [9:0] BASEBAND_CONFIGURATION_OFS = 10'h038;

   // Reset values
   localparam logic [7:0] MAC_CONTROL_ONE_RST = 8'h0c;
   localparam logic [7:0] RATE_CONFIGURATION_RST = 8'h03;
   localparam logic [7:0] BASEBAND_CONFIGURATION_RST = 8'h31;

   ////////////////////////////////////////////////////////////////////////
   // Field positions, mac_control_one
   localparam int MODE_MSB = 7;
   localparam int MODE_LSB = 6;
   localparam int ADDR_SIZE_MSB = 5;
   localparam int ADDR_SIZE_LSB = 3;
   localparam int CHECKSUM_SIZE_BIT = 2;
   localparam int FRAME_FORMAT_BIT = 1;
   localparam int SEC_FLAG_OVR_BIT = 0;

   // Field positions, rate_configuration
   localparam int REJ_2M_BIT = 7;
   localparam int REJ_1M_BIT = 6;
   localparam int REJ_500K_BIT = 5;
   localparam int REJ_250K_NONSTD_BIT = 4;
   localparam int REJ_250K_STD_BIT = 3;
   localparam int REJ_125K_BIT = 2;
   localparam int OPTIMIZED_PRMB_BIT = 1;
   localparam int POWER_SAVE_BIT = 0;

   // Field positions, baseband_configuration
   localparam int RANDOM_MOD_BIT = 7;
   localparam int FREQ_OFS_OVR_BIT = 6;
   localparam int GAIN_MSB = 5;
   localparam int GAIN_LSB = 4;
   localparam int PRMB_HOLD_BIT = 3;
   localparam int PRMB_SIZE_MSB = 2;
   localparam int PRMB_SIZE_LSB = 0;

   ////////////////////////////////////////////////////////////////////////
   // Buffer handling modes
   localparam logic [1:0] MODE_PACKET = 2'h0;
   localparam logic [1:0] MODE_RX_STREAM = 2'h1;
   localparam logic [1:0] MODE_TX_STREAM = 2'h2;

   // Receiver gain codes
   localparam logic [1:0] GAIN_AUTO = 2'h3;

   // Air rate codes (250 kbps fixed, the others chosen locally)
   localparam logic [2:0] RATE_125K = 3'h2;
   localparam logic [2:0] RATE_250K = 3'h3;
   localparam logic [2:0] RATE_500K = 3'h4;
   localparam logic [2:0] RATE_1M = 3'h5;
   localparam logic [2:0] RATE_2M = 3'h6;

   // Receive rate classes reported by the demodulator
   localparam logic [2:0] RXC_125K = 3'h0;
   localparam logic [2:0] RXC_250K_STD = 3'h1;
   localparam logic [2:0] RXC_250K_NONSTD = 3'h2;
   localparam logic [2:0] RXC_500K = 3'h3;
   localparam logic [2:0] RXC_1M = 3'h4;
   localparam logic [2:0] RXC_2M = 3'h5;

   ////////////////////////////////////////////////////////////////////////
   // Preamble timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int PRMB_UNIT_SLOW_NS = 16000;
   localparam int PRMB_UNIT_FAST_NS = 4000;
   localparam int PRMB_UNIT_LEGACY_NS = 32000;
   localparam int PRMB_BASE_SLOW = 4;
   localparam int PRMB_BASE_FAST = 8;
   localparam int PRMB_LEGACY_UNITS = 8;
   localparam logic [11:0] PRMB_UNIT_SLOW_CYC =
      12'(PRMB_UNIT_SLOW_NS / CLK_PERIOD_NS);
   localparam logic [11:0] PRMB_UNIT_FAST_CYC =
      12'(PRMB_UNIT_FAST_NS / CLK_PERIOD_NS);
   localparam logic [11:0] PRMB_UNIT_LEGACY_CYC =
      12'(PRMB_UNIT_LEGACY_NS / CLK_PERIOD_NS);

   // Preamble sequencer states
   typedef enum logic [0:0] {MRPC_PRMB_IDLE, MRPC_PRMB_RUN} mrpc_prmb_t;

endpackage

// ---- hdl/mrpc_preamble_seq.sv ----
// Preamble sequencer: counts preamble units, holds them out on request.
// Assumes the caller gives a stable unit length and count per frame.
`timescale 1ns/1ps
module mrpc_preamble_seq (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic start,
   input wire logic hold,
   input wire logic random_mod,
   input wire logic [11:0] unit_cycles,
   input wire logic [3:0] unit_count,
   output logic active,
   output logic random_out,
   output logic header_start
);
   import mrpc_pkg::*;

   mrpc_prmb_t state_reg, state_next;  // Sequencer state
   logic [11:0] cyc_reg, cyc_next;     // Cycles into current unit
   logic [3:0] unit_reg, unit_next;    // Units sent so far
   logic hdr_reg, hdr_next;            // Header start pulse
   logic last_cyc;                     // Current unit ends this cycle

   ////////////////////////////////////////////////////////////////////////
   // Next state; hold is only sampled at a unit boundary so a unit is
   // never cut short when the hold is released
   always_comb begin
      state_next = state_reg;
      cyc_next = cyc_reg;
      unit_next = unit_reg;
      hdr_next = 1'b0;
      last_cyc = (cyc_reg == unit_cycles - 12'h001);
      unique case (state_reg)
         MRPC_PRMB_IDLE: begin
            cyc_next = 12'h000;
            unit_next = 4'h0;
            if (start) begin
               state_next = MRPC_PRMB_RUN;
            end
         end
         MRPC_PRMB_RUN: begin
            if (!last_cyc) begin
               cyc_next = cyc_reg + 12'h001;
            end else begin
               cyc_next = 12'h000;
               // Saturate so an endless hold cannot wrap the count
               if (unit_reg != 4'hf) begin
                  unit_next = unit_reg + 4'h1;
               end
               // Finish after the current unit once hold is gone and the count is met
               if (!hold && (unit_next >= unit_count)) begin
                  state_next = MRPC_PRMB_IDLE;
                  hdr_next = 1'b1;
               end
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_reg <= MRPC_PRMB_IDLE;
         cyc_reg <= 12'h000;
         unit_reg <= 4'h0;
         hdr_reg <= 1'b0;
         active <= 1'b0;
         random_out <= 1'b0;
      end else begin
         state_reg <= state_next;
         cyc_reg <= cyc_next;
         unit_reg <= unit_next;
         hdr_reg <= hdr_next;
         active <= (state_next == MRPC_PRMB_RUN);
         // Test only: random chips replace held preamble
         random_out <= (state_next == MRPC_PRMB_RUN) && hold
            && random_mod;
      end
   end

   assign header_start = hdr_reg;

endmodule

// ---- hdl/mrpc_config.sv ----
// MAC, rate and baseband configuration registers with their side effects.
// Assumes host register writes arrive as one-cycle strobes in clk domain.
`timescale 1ns/1ps
module mrpc_config (
   input wire logic clk,
   input wire logic sys_rst,
   // Register access from the host port
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [mrpc_pkg::REG_ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Side effects on bits held in other registers
   output logic rx_enable_set,
   output logic rx_enable_clear,
   output logic tx_start_clear,
   output logic tx_crypt_clear,
   // Buffer steering
   input wire logic tx_frame_done,
   input wire logic rx_frame_done,
   output logic tx_buf_sel,
   output logic rx_buf_sel,
   output logic tx_window_en,
   output logic rx_window_en,
   // Received frame classification
   input wire logic rx_hdr_valid,
   input wire logic [2:0] rx_rate_class,
   input wire logic rx_proprietary,
   input wire logic rx_streaming_type,
   output logic rx_frame_drop,
   output logic ack_proprietary,
   // Framing settings
   output logic frame_proprietary,
   output logic [3:0] addr_octets,
   output logic [1:0] fcs_octets,
   output logic sec_flags_override,
   input wire logic frame_security_enable,
   output logic tx_sec_process,
   // Receiver front end settings
   output logic power_save_detection,
   output logic agc_enable,
   output logic [1:0] fixed_gain,
   output logic freq_offset_override,
   // Transmit preamble
   input wire logic [2:0] transmit_rate_field,
   input wire logic tx_frame_start,
   output logic optimized_preamble,
   output logic [3:0] preamble_units,
   output logic preamble_active,
   output logic preamble_random,
   output logic header_start
);
   import mrpc_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [7:0] mac_control_one_reg, mac_control_one_next;
   logic [7:0] rate_configuration_reg, rate_configuration_next;
   logic [7:0] baseband_configuration_reg, baseband_configuration_next;
   logic [7:0] rdata_next;           // Read mux result
   logic wr_mac;                     // Write to mac_control_one
   logic [1:0] wr_mode;              // Mode being written
   logic rx_set_next, rx_clr_next;   // Side effect pulses
   logic transmit_start_bit_clr_next, crypt_clr_next;
   logic tx_sel_next, rx_sel_next;   // Physical buffer choices
   logic tx_win_next, rx_win_next;   // Window enables
   logic drop_next, ack_fmt_next;    // Received frame verdicts
   logic [3:0] units_next;           // Preamble length in units
   logic [11:0] unit_cyc_reg, unit_cyc_next;
   logic [1:0] mode;                 // Current buffer handling mode
   logic prmb_start_reg;             // Delayed frame start

   // Receive rate class to its disable bit position
   function automatic logic rate_rejected(input logic [7:0] rc,
                                          input logic [2:0] cls);
      unique case (cls)
         RXC_125K: rate_rejected = rc[REJ_125K_BIT];
         RXC_250K_STD: rate_rejected = rc[REJ_250K_STD_BIT];
         RXC_250K_NONSTD: rate_rejected = rc[REJ_250K_NONSTD_BIT];
         RXC_500K: rate_rejected = rc[REJ_500K_BIT];
         RXC_1M: rate_rejected = rc[REJ_1M_BIT];
         RXC_2M: rate_rejected = rc[REJ_2M_BIT];
         // Unknown class: refuse rather than accept garbage
         default: rate_rejected = 1'b1;
      endcase
   endfunction

   assign mode = mac_control_one_reg[MODE_MSB:MODE_LSB];

   ////////////////////////////////////////////////////////////////////////
   // Register file next values and write side effects
   always_comb begin
      mac_control_one_next = mac_control_one_reg;
      rate_configuration_next = rate_configuration_reg;
      baseband_configuration_next = baseband_configuration_reg;
      wr_mac = reg_wr_en && (reg_addr == MAC_CONTROL_ONE_OFS);
      wr_mode = reg_wdata[MODE_MSB:MODE_LSB];
      rx_set_next = 1'b0;
      rx_clr_next = 1'b0;
      transmit_start_bit_clr_next = 1'b0;
      crypt_clr_next = 1'b0;
      if (wr_mac) begin
         mac_control_one_next = reg_wdata;
         // Mode writes reach into transmit and receive control
         if (wr_mode == MODE_TX_STREAM) begin
            rx_clr_next = 1'b1;
         end else if (wr_mode == MODE_RX_STREAM) begin
            transmit_start_bit_clr_next = 1'b1;
            crypt_clr_next = 1'b1;
            rx_set_next = 1'b1;
         end
      end
      if (reg_wr_en && (reg_addr == RATE_CONFIGURATION_OFS)) begin
         rate_configuration_next = reg_wdata;
      end
      if (reg_wr_en && (reg_addr == BASEBAND_CONFIGURATION_OFS)) begin
         baseband_configuration_next = reg_wdata;
      end
      // Reads of unmapped addresses return zero
      unique case (reg_addr)
         MAC_CONTROL_ONE_OFS: rdata_next = mac_control_one_reg;
         RATE_CONFIGURATION_OFS: rdata_next = rate_configuration_reg;
         BASEBAND_CONFIGURATION_OFS:
            rdata_next = baseband_configuration_reg;
         default: rdata_next = 8'h00;
      endcase
      if (!reg_rd_en) begin
         rdata_next = reg_rdata;
      end
   end

   // Registers of the register file
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mac_control_one_reg <= MAC_CONTROL_ONE_RST;
         rate_configuration_reg <= RATE_CONFIGURATION_RST;
         baseband_configuration_reg <= BASEBAND_CONFIGURATION_RST;
         reg_rdata <= 8'h00;
         rx_enable_set <= 1'b0;
         rx_enable_clear <= 1'b0;
         tx_start_clear <= 1'b0;
         tx_crypt_clear <= 1'b0;
      end else begin
         mac_control_one_reg <= mac_control_one_next;
         rate_configuration_reg <= rate_configuration_next;
         baseband_configuration_reg <= baseband_configuration_next;
         reg_rdata <= rdata_next;
         rx_enable_set <= rx_set_next;
         rx_enable_clear <= rx_clr_next;
         tx_start_clear <= transmit_start_bit_clr_next;
         tx_crypt_clear <= crypt_clr_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Buffer steering: 0 selects buffer one, 1 selects buffer two.
   // In streaming modes the host window alternates each finished frame;
   // a mode write restarts the alternation on buffer one.
   always_comb begin
      tx_sel_next = tx_buf_sel;
      rx_sel_next = rx_buf_sel;
      tx_win_next = 1'b1;
      rx_win_next = 1'b1;
      if (wr_mac) begin
         tx_sel_next = 1'b0;
         rx_sel_next = (wr_mode == MODE_PACKET);
         tx_win_next = (wr_mode != MODE_RX_STREAM);
         rx_win_next = (wr_mode != MODE_TX_STREAM);
      end else begin
         unique case (mode)
            MODE_PACKET: begin
               tx_sel_next = 1'b0;
               rx_sel_next = 1'b1;
            end
            MODE_TX_STREAM: begin
               rx_win_next = 1'b0;
               if (tx_frame_done) begin
                  tx_sel_next = !tx_buf_sel;
               end
            end
            MODE_RX_STREAM: begin
               tx_win_next = 1'b0;
               if (rx_frame_done) begin
                  rx_sel_next = !rx_buf_sel;
               end
            end
            // Reserved mode: neither window is defined
            default: begin
               tx_win_next = 1'b0;
               rx_win_next = 1'b0;
            end
         endcase
      end
   end

   // Buffer steering registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tx_buf_sel <= 1'b0;
         rx_buf_sel <= 1'b1;
         tx_window_en <= 1'b1;
         rx_window_en <= 1'b1;
      end else begin
         tx_buf_sel <= tx_sel_next;
         rx_buf_sel <= rx_sel_next;
         tx_window_en <= tx_win_next;
         rx_window_en <= rx_win_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Received frame verdict, taken once per header
   always_comb begin
      drop_next = rx_frame_drop;
      ack_fmt_next = ack_proprietary;
      if (rx_hdr_valid) begin
         drop_next = rate_rejected(rate_configuration_reg,
            rx_rate_class);
         if (mode == MODE_RX_STREAM && rx_proprietary
            && !rx_streaming_type) begin
            drop_next = 1'b1;
         end
         // Acknowledge goes back in the format it answers
         ack_fmt_next = rx_proprietary;
      end
   end

   // Verdict registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rx_frame_drop <= 1'b0;
         ack_proprietary <= 1'b0;
      end else begin
         rx_frame_drop <= drop_next;
         ack_proprietary <= ack_fmt_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Decoded settings, registered so every output leaves a flip-flop
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         frame_proprietary <= 1'b0;
         addr_octets <= 4'h2;
         fcs_octets <= 2'h2;
         sec_flags_override <= 1'b0;
         tx_sec_process <= 1'b0;
         power_save_detection <= 1'b1;
         agc_enable <= 1'b1;
         fixed_gain <= 2'h3;
         freq_offset_override <= 1'b0;
         optimized_preamble <= 1'b1;
      end else begin
         frame_proprietary <= mac_control_one_next[FRAME_FORMAT_BIT];
         // Size only matters to proprietary framing
         addr_octets <= {1'b0,
            mac_control_one_next[ADDR_SIZE_MSB:ADDR_SIZE_LSB]}
            + 4'h1;
         fcs_octets <= mac_control_one_next[CHECKSUM_SIZE_BIT]
            ? 2'h2 : 2'h0;
         sec_flags_override <= mac_control_one_next[SEC_FLAG_OVR_BIT];
         // No setting gates this off, in either frame format
         tx_sec_process <= frame_security_enable;
         power_save_detection <= rate_configuration_next[POWER_SAVE_BIT];
         agc_enable <= (baseband_configuration_next[GAIN_MSB:GAIN_LSB]
            == GAIN_AUTO);
         fixed_gain <= baseband_configuration_next[GAIN_MSB:GAIN_LSB];
         freq_offset_override <=
            baseband_configuration_next[FREQ_OFS_OVR_BIT];
         optimized_preamble <=
            rate_configuration_next[OPTIMIZED_PRMB_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Preamble length and unit time; size field only counts for the
   // optimized preamble at 500 kbps and above
   always_comb begin
      units_next = 4'(PRMB_LEGACY_UNITS);
      unit_cyc_next = PRMB_UNIT_LEGACY_CYC;
      if (rate_configuration_reg[OPTIMIZED_PRMB_BIT]) begin
         if (transmit_rate_field == RATE_500K) begin
            units_next = 4'(PRMB_BASE_SLOW)
               + {3'h0, baseband_configuration_reg[PRMB_SIZE_MSB]};
            unit_cyc_next = PRMB_UNIT_SLOW_CYC;
         end else if (transmit_rate_field == RATE_1M
            || transmit_rate_field == RATE_2M) begin
            units_next = 4'(PRMB_BASE_FAST) + {2'h0,
               baseband_configuration_reg[PRMB_SIZE_LSB+1:PRMB_SIZE_LSB]};
            unit_cyc_next = PRMB_UNIT_FAST_CYC;
         end
      end
   end

   // Preamble length registers; the start is delayed one cycle so the
   // sequencer sees length and unit time already settled
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         preamble_units <= 4'(PRMB_LEGACY_UNITS);
         unit_cyc_reg <= PRMB_UNIT_LEGACY_CYC;
         prmb_start_reg <= 1'b0;
      end else begin
         preamble_units <= units_next;
         unit_cyc_reg <= unit_cyc_next;
         prmb_start_reg <= tx_frame_start;
      end
   end

   // Preamble sequencer
   mrpc_preamble_seq u_prmb (
      .clk(clk),
      .sys_rst(sys_rst),
      .start(prmb_start_reg),
      .hold(baseband_configuration_reg[PRMB_HOLD_BIT]),
      .random_mod(baseband_configuration_reg[RANDOM_MOD_BIT]),
      .unit_cycles(unit_cyc_reg),
      .unit_count(preamble_units),
      .active(preamble_active),
      .random_out(preamble_random),
      .header_start(header_start)
   );

endmodule

// ---- test/mrpc_host.sv ----
// Host model: drives the register strobes of the configuration block.
// Assumes bench calls wr and rd one at a time from one process.
`timescale 1ns/1ps
module mrpc_host (
   input wire logic clk,
   input wire logic [7:0] reg_rdata,
   output logic reg_wr_en,
   output logic reg_rd_en,
   output logic [mrpc_pkg::REG_ADDR_W-1:0] reg_addr,
   output logic [7:0] reg_wdata
);
   import mrpc_pkg::*;
   // Idle bus at time zero
   initial begin
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr = 10'h3ff;
      reg_wdata = 8'h00;
   end
   // One-cycle write; callers keep format and sizes fixed mid-traffic
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      reg_wr_en = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clk);
      #1;
      reg_wr_en = 1'b0;
      reg_wdata = ~d; // Released data shows no stale value
   endtask
   // One-cycle read; data settles at the taking edge
   task automatic rd(input logic [9:0] a, output logic [7:0] d);
      @(posedge clk);
      #1;
      reg_rd_en = 1'b1;
      reg_addr = a;
      @(posedge clk);
      #1;
      reg_rd_en = 1'b0;
      d = reg_rdata;
   endtask
endmodule

// ---- test/mrpc_config_asserts.sv ----
// Checker for register side effects, decoded settings and preamble end.
// Assumes it is bound to mrpc_config and sees only its ports.
`timescale 1ns/1ps
module mrpc_config_asserts import mrpc_pkg::*; (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic reg_wr_en,
   input wire logic [mrpc_pkg::REG_ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic rx_enable_set,
   input wire logic rx_enable_clear,
   input wire logic tx_start_clear,
   input wire logic tx_crypt_clear,
   input wire logic tx_buf_sel,
   input wire logic rx_buf_sel,
   input wire logic [3:0] addr_octets,
   input wire logic [1:0] fcs_octets,
   input wire logic optimized_preamble,
   input wire logic power_save_detection,
   input wire logic agc_enable,
   input wire logic [1:0] fixed_gain,
   input wire logic preamble_active,
   input wire logic header_start
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic mw, rw, bw; // Writes to each register
   assign mw = reg_wr_en && reg_addr == MAC_CONTROL_ONE_OFS;
   assign rw = reg_wr_en && reg_addr == RATE_CONFIGURATION_OFS;
   assign bw = reg_wr_en && reg_addr == BASEBAND_CONFIGURATION_OFS;
   ////////////////////////////////////////////////////////////////////////
   mode_rx_a: assert property (
      mw && reg_wdata[7:6] == MODE_RX_STREAM |=> rx_enable_set &&
      tx_start_clear && tx_crypt_clear && !rx_buf_sel)
      else $error("rx stream side effects missing");
   mode_tx_a: assert property (
      mw && reg_wdata[7:6] == MODE_TX_STREAM |=>
      rx_enable_clear && !rx_enable_set && !tx_buf_sel)
      else $error("tx stream side effects missing");
   mode_pkt_a: assert property (
      mw && reg_wdata[7:6] == MODE_PACKET |=> !tx_buf_sel && rx_buf_sel)
      else $error("packet mode buffers wrong");
   addr_len_a: assert property (
      mw |=> addr_octets == 4'($past(reg_wdata[5:3])) + 4'h1)
      else $error("address length wrong");
   fcs_size_a: assert property (
      mw |=> fcs_octets == ($past(reg_wdata[2]) ? 2'h2 : 2'h0))
      else $error("checksum size wrong");
   prmb_sel_a: assert property (
      rw |=> optimized_preamble == $past(reg_wdata[1]) &&
      power_save_detection == $past(reg_wdata[0]))
      else $error("preamble or power save select wrong");
   gain_code_a: assert property (
      bw |=> fixed_gain == $past(reg_wdata[5:4]) &&
      agc_enable == (fixed_gain == GAIN_AUTO))
      else $error("gain decode wrong");
   hdr_end_a: assert property (
      header_start |-> $past(preamble_active) && !preamble_active)
      else $error("header start outside preamble end");
endmodule
bind mrpc_config mrpc_config_asserts chk_u (.*);

// ---- test/mrpc_config_bench.sv ----
// Self-checking bench for the configuration block with a host model.
// Assumes 125 MHz clock; inputs change 1 ns after the rising edge.
`timescale 1ns/1ps
module mrpc_config_bench;
   import mrpc_pkg::*;
   logic clk, sys_rst, reg_wr_en, reg_rd_en, rx_enable_set, rx_enable_clear;
   logic tx_start_clear, tx_crypt_clear, tx_frame_done, rx_frame_done;
   logic tx_buf_sel, rx_buf_sel, tx_window_en, rx_window_en, rx_hdr_valid;
   logic rx_proprietary, rx_streaming_type, rx_frame_drop, ack_proprietary;
   logic frame_proprietary, sec_flags_override, frame_security_enable;
   logic tx_sec_process, power_save_detection, agc_enable, tx_frame_start;
   logic freq_offset_override, optimized_preamble, preamble_active;
   logic preamble_random, header_start;
   logic [9:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, r;
   logic [7:0] v [3];
   logic [2:0] rx_rate_class, transmit_rate_field;
   logic [3:0] addr_octets, preamble_units;
   logic [1:0] fcs_octets, fixed_gain, m;
   int err_count, checks_done, seed, i, j, n;
   logic [9:0] ofs [3] = '{MAC_CONTROL_ONE_OFS, RATE_CONFIGURATION_OFS,
                           BASEBAND_CONFIGURATION_OFS};
   mrpc_host host_u (.clk(clk), .reg_rdata(reg_rdata), .reg_wr_en(reg_wr_en),
      .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
   mrpc_config dut_u (.*);
   // 8 ns clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Compare and count
   task automatic chk(input string s, input logic [15:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", s, exp, seen);
      end
   endtask
   // Expected preamble length in units
   function automatic logic [3:0] units(logic [2:0] dr, logic [7:0] rc, bc);
      if (!rc[1]) return 4'h8;
      if (dr == RATE_500K) return 4'h4 + 4'(bc[2]);
      if (dr == RATE_1M || dr == RATE_2M) return 4'h8 + 4'(bc[1:0]);
      return 4'h8;
   endfunction
   // One classified header
   task automatic hdr(input logic [2:0] c, input logic p, s);
      rx_rate_class = c;
      rx_proprietary = p;
      rx_streaming_type = s;
      rx_hdr_valid = 1'b1;
      @(posedge clk);
      #1 rx_hdr_valid = 1'b0;
      #8;
   endtask
   // Wait for header start, bounded
   task automatic wh(input int lim, output int k);
      k = 0;
      while (header_start !== 1'b1 && k < lim) begin
         @(posedge clk);
         #1 k++;
      end
   endtask
   task automatic start_prmb();
      tx_frame_start = 1'b1;
      @(posedge clk);
      #1 tx_frame_start = 1'b0;
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Watchdog: the run needs under 30k cycles
   initial begin
      #(8 * 30000);
      err_count++;
      end_sim();
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      seed = 67168;
      sys_rst = 1'b1;
      {tx_frame_done, rx_frame_done, rx_hdr_valid, rx_proprietary} = 4'h0;
      {rx_streaming_type, frame_security_enable, tx_frame_start} = 3'h0;
      rx_rate_class = 3'h0;
      transmit_rate_field = RATE_250K;
      repeat (5) @(posedge clk);
      #1 sys_rst = 1'b0;
      host_u.rd(ofs[0], r); chk("mac rst", r, MAC_CONTROL_ONE_RST);
      host_u.rd(ofs[1], r); chk("rate rst", r, RATE_CONFIGURATION_RST);
      host_u.rd(ofs[2], r); chk("bb rst", r, BASEBAND_CONFIGURATION_RST);
      host_u.rd(10'h3ff, r); chk("unmapped", r, 8'h00);
      // Random settings, read back and decoded
      for (i = 0; i < 24; i++) begin
         for (j = 0; j < 3; j++) v[j] = 8'($random(seed));
         if (!v[0][1] || v[0][7:6] == 2'h3) v[0][7:6] = MODE_PACKET;
         v[2][3] = 1'b0;
         frame_security_enable = 1'($random(seed));
         transmit_rate_field = 3'h2 + 3'($unsigned($random(seed)) % 5);
         for (j = 0; j < 3; j++) host_u.wr(ofs[j], v[j]);
         for (j = 0; j < 3; j++) begin
            host_u.rd(ofs[j], r);
            chk("readback", r, v[j]);
         end
         chk("format", frame_proprietary, v[0][1]);
         chk("sec ovr", sec_flags_override, v[0][0]);
         chk("sec proc", tx_sec_process, frame_security_enable);
         chk("units", preamble_units, units(transmit_rate_field, v[1], v[2]));
      end
      // Modes, side effects, buffers and streaming drop
      host_u.wr(ofs[1], 8'h03);
      host_u.wr(ofs[2], 8'h11);
      for (i = 0; i < 3; i++) begin
         m = 2'(i);
         host_u.wr(ofs[0], {m, 6'h0e});
         chk("rx set", rx_enable_set, m == MODE_RX_STREAM);
         chk("rx clr", rx_enable_clear, m == MODE_TX_STREAM);
         chk("tx win", tx_window_en, m != MODE_RX_STREAM);
         chk("rx win", rx_window_en, m != MODE_TX_STREAM);
         {tx_frame_done, rx_frame_done} = 2'h3;
         @(posedge clk);
         #1 {tx_frame_done, rx_frame_done} = 2'h0;
         chk("tx buf", tx_buf_sel, m == MODE_TX_STREAM);
         chk("rx buf", rx_buf_sel, m != MODE_TX_STREAM);
         hdr(RXC_250K_STD, 1'b1, 1'b0);
         chk("drop", rx_frame_drop, m == MODE_RX_STREAM);
         chk("ack fmt", ack_proprietary, 1'b1);
         hdr(RXC_250K_STD, 1'b1, 1'b1);
         chk("keep", rx_frame_drop, 1'b0);
      end
      // Each rate reject bit, then the standard-only setting
      host_u.wr(ofs[0], 8'h0e);
      for (i = 0; i < 6; i++) begin
         host_u.wr(ofs[1], 8'h03 | (8'h04 << i));
         hdr(3'(i), 1'b0, 1'b0);
         chk("rej", rx_frame_drop, 1'b1);
         hdr(3'((i + 1) % 6), 1'b0, 1'b0);
         chk("acc", rx_frame_drop, 1'b0);
      end
      host_u.wr(ofs[1], 8'hf7);
      hdr(RXC_250K_STD, 1'b0, 1'b0);
      chk("std", rx_frame_drop, 1'b0);
      // Preamble length at 2 Mbps, size 3: 11 units of 500 cycles
      host_u.wr(ofs[2], 8'h33);
      transmit_rate_field = RATE_2M;
      start_prmb();
      wh(8000, n);
      chk("prmb len", n >= 5500 && n <= 5504, 1'b1);
      // Held preamble with random symbols, then release mid-unit
      host_u.wr(ofs[2], 8'hb8);
      transmit_rate_field = RATE_500K;
      start_prmb();
      wh(10000, n);
      chk("held", n, 16'd10000);
      chk("random", preamble_random, 1'b1);
      host_u.wr(ofs[2], 8'h30);
      wh(5000, n);
      chk("release", n < 2010, 1'b1);
      end_sim();
   end
endmodule
